// [rtl/alu_imm_addsub.sv]
// Execution stage for compact-format immediate and register add, subtract and compare
`timescale 1ns/1ps
`default_nettype none

module alu_imm_addsub
  import alu_imm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic OP_VALID,
  input wire logic [OPC_W-1:0] OP_CODE,
  input wire logic MODE_64,
  input wire logic KERNEL_MODE,
  input wire logic [XLEN-1:0] RX_VAL,
  input wire logic [XLEN-1:0] RY_VAL,
  input wire logic [XLEN-1:0] SP_VAL,
  input wire logic [XLEN-1:0] BASE_PC,
  input wire logic [IMM_W-1:0] IMM,
  input wire logic [REGN_W-1:0] RX_NUM,
  input wire logic [REGN_W-1:0] RY_NUM,
  input wire logic [REGN_W-1:0] RZ_NUM,
  output logic WB_VALID,
  output logic [REGN_W-1:0] WB_REG,
  output logic [XLEN-1:0] WB_DATA,
  output logic RSV_TRAP,
  output logic OVF_TRAP
);

  // ==========================================================
  // Helper functions

  // Word result widened: sign-extended in 64-bit mode, zero upper half otherwise
  function automatic logic [XLEN-1:0] widen_word(input logic [WLEN-1:0] w,
                                                input logic wide);
    logic [XLEN-1:0] r;
    r = {32'h0, w};
    if (wide) begin
      r = {{32{w[WLEN-1]}}, w};
    end
    return r;
  endfunction

  // Zero extension of the immediate field up to msb, then scaled left
  function automatic logic [XLEN-1:0] zext_imm(input logic [IMM_W-1:0] v,
                                              input int msb,
                                              input int sh);
    logic [XLEN-1:0] r;
    r = {56'h0, v};
    r = (r << (XLEN - 1 - msb)) >> (XLEN - 1 - msb);
    r = r << sh;
    return r;
  endfunction

  // Sign extension of the immediate field up to msb, then scaled left
  function automatic logic [XLEN-1:0] sext_imm(input logic [IMM_W-1:0] v,
                                              input int msb,
                                              input int sh);
    logic [XLEN-1:0] r;
    r = {56'h0, v};
    r = XLEN'($signed(r << (XLEN - 1 - msb)) >>> (XLEN - 1 - msb));
    r = r << sh;
    return r;
  endfunction

  // ==========================================================
  // Decode outputs and datapath wires
  logic [XLEN-1:0] opa;
  logic [XLEN-1:0] opb;
  logic sub;
  logic [XLEN-1:0] raw_val;
  logic [REGN_W-1:0] dest;
  form_t form;
  logic is_dword;
  logic known;
  logic trap;
  logic [XLEN-1:0] pc_masked;
  logic [XLEN-1:0] sum;
  logic lt_s;
  logic lt_u;
  logic [XLEN-1:0] result;

  // Registered write-back stage
  logic wb_valid_ff;
  logic nxt_wb_valid;
  logic [REGN_W-1:0] wb_reg_ff;
  logic [REGN_W-1:0] nxt_wb_reg;
  logic [XLEN-1:0] wb_data_ff;
  logic [XLEN-1:0] nxt_wb_data;
  logic rsv_trap_ff;
  logic nxt_rsv_trap;
  logic ovf_trap_ff;
  logic nxt_ovf_trap;

  // Base PC with its low two bits cleared
  assign pc_masked = {BASE_PC[XLEN-1:PC_MASK_BITS], {PC_MASK_BITS{1'b0}}};

  // ==========================================================
  // Operation decode: operands, destination and result form
  always_comb begin
    opa = RX_VAL;
    opb = '0;
    sub = 1'b0;
    raw_val = '0;
    dest = RX_NUM;
    form = FORM_WORD;
    is_dword = 1'b0;
    known = 1'b1;
    case (OP_CODE)
      load_immediate_op: begin
        raw_val = zext_imm(IMM, IMM8_MSB, 0);
        form = FORM_RAW;
      end
      add_immediate_wrap_op_3op: begin
        opb = sext_imm(IMM, IMM4_MSB, 0);
        dest = RY_NUM;
      end
      add_immediate_wrap_op_2op: begin
        opb = sext_imm(IMM, IMM8_MSB, 0);
      end
      add_immediate_wrap_op_sp: begin
        opa = SP_VAL;
        opb = sext_imm(IMM, IMM8_MSB, SP_ADJ_SHIFT);
        dest = SP_REG_NUM;
      end
      add_immediate_wrap_op_pc: begin
        opa = pc_masked;
        opb = zext_imm(IMM, IMM8_MSB, WORD_SHIFT);
        form = FORM_DWORD;
      end
      add_immediate_wrap_op_sprel: begin
        opa = SP_VAL;
        opb = zext_imm(IMM, IMM8_MSB, WORD_SHIFT);
      end
      set_less_imm_signed_op: begin
        opb = zext_imm(IMM, IMM8_MSB, 0);
        sub = 1'b1;
        dest = TEST_REG_NUM;
        form = FORM_LT_SIGNED;
      end
      set_less_imm_unsigned_op: begin
        opb = zext_imm(IMM, IMM8_MSB, 0);
        sub = 1'b1;
        dest = TEST_REG_NUM;
        form = FORM_LT_UNSIGNED;
      end
      xor_compare_immediate_op: begin
        raw_val = RX_VAL ^ zext_imm(IMM, IMM8_MSB, 0);
        dest = TEST_REG_NUM;
        form = FORM_RAW;
      end
      add_wrap_op: begin
        opb = RY_VAL;
        dest = RZ_NUM;
      end
      subtract_wrap_op: begin
        opb = RY_VAL;
        sub = 1'b1;
        dest = RZ_NUM;
      end
      dword_add_immediate_wrap_op_3op: begin
        opb = sext_imm(IMM, IMM4_MSB, 0);
        dest = RY_NUM;
        form = FORM_DWORD;
        is_dword = 1'b1;
      end
      dword_add_immediate_wrap_op_2op: begin
        opa = RY_VAL;
        opb = sext_imm(IMM, IMM5_MSB, 0);
        dest = RY_NUM;
        form = FORM_DWORD;
        is_dword = 1'b1;
      end
      dword_add_immediate_wrap_op_sp: begin
        opa = SP_VAL;
        opb = sext_imm(IMM, IMM8_MSB, SP_ADJ_SHIFT);
        dest = SP_REG_NUM;
        form = FORM_DWORD;
        is_dword = 1'b1;
      end
      dword_add_immediate_wrap_op_pc: begin
        opa = pc_masked;
        opb = zext_imm(IMM, IMM5_MSB, WORD_SHIFT);
        dest = RY_NUM;
        form = FORM_DWORD;
        is_dword = 1'b1;
      end
      dword_add_immediate_wrap_op_sprel: begin
        opa = SP_VAL;
        opb = zext_imm(IMM, IMM5_MSB, WORD_SHIFT);
        dest = RY_NUM;
        form = FORM_DWORD;
        is_dword = 1'b1;
      end
      dword_add_wrap_op: begin
        opb = RY_VAL;
        dest = RZ_NUM;
        form = FORM_DWORD;
        is_dword = 1'b1;
      end
      dword_subtract_wrap_op: begin
        opb = RY_VAL;
        sub = 1'b1;
        dest = RZ_NUM;
        form = FORM_DWORD;
        is_dword = 1'b1;
      end
      set_less_signed_op: begin
        opb = RY_VAL;
        sub = 1'b1;
        dest = TEST_REG_NUM;
        form = FORM_LT_SIGNED;
      end
      set_less_unsigned_op: begin
        opb = RY_VAL;
        sub = 1'b1;
        dest = TEST_REG_NUM;
        form = FORM_LT_UNSIGNED;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Shared adder; comparisons are taken on an extra bit
  addsub_unit #(
    .WIDTH(XLEN)
  ) u_addsub (
    .opa(opa),
    .opb(opb),
    .sub(sub),
    .result(sum),
    .lt_signed(lt_s),
    .lt_unsigned(lt_u)
  );

  // ==========================================================
  // Result shaping by form
  always_comb begin
    case (form)
      FORM_WORD: result = widen_word(sum[WLEN-1:0], MODE_64);
      FORM_DWORD: result = sum;
      FORM_LT_SIGNED: result = {63'h0, lt_s};
      FORM_LT_UNSIGNED: result = {63'h0, lt_u};
      FORM_RAW: result = raw_val;
      default: result = '0;
    endcase
  end

  // Doubleword opcodes (is_dword) are reserved unless 64-bit or kernel mode is set
  assign trap = OP_VALID & known & is_dword & ~MODE_64 & ~KERNEL_MODE;

  // ==========================================================
  // Next values of the write-back stage
  always_comb begin
    nxt_wb_valid = OP_VALID & known & ~trap;
    nxt_wb_reg = wb_reg_ff;
    nxt_wb_data = wb_data_ff;
    nxt_rsv_trap = trap;
    nxt_ovf_trap = 1'b0;
    if (nxt_wb_valid) begin
      nxt_wb_reg = dest;
      nxt_wb_data = result;
    end
  end

  // ==========================================================
  // Write-back stage registers
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wb_valid_ff <= 1'b0;
      wb_reg_ff <= WB_REG_RST;
      wb_data_ff <= WB_DATA_RST;
      rsv_trap_ff <= 1'b0;
      ovf_trap_ff <= 1'b0;
    end else begin
      wb_valid_ff <= nxt_wb_valid;
      wb_reg_ff <= nxt_wb_reg;
      wb_data_ff <= nxt_wb_data;
      rsv_trap_ff <= nxt_rsv_trap;
      ovf_trap_ff <= nxt_ovf_trap;
    end
  end

  // Outputs straight from flip-flops
  assign WB_VALID = wb_valid_ff;
  assign WB_REG = wb_reg_ff;
  assign WB_DATA = wb_data_ff;
  assign RSV_TRAP = rsv_trap_ff;
  assign OVF_TRAP = ovf_trap_ff;

endmodule

`default_nettype wire

// [pkg/alu_imm_pkg.sv]
// Constants, operation codes and helper types of the compact add/subtract datapath
package alu_imm_pkg;

  // ==========================================================
  // Widths
  localparam int XLEN = 64;
  localparam int WLEN = 32;
  localparam int REGN_W = 5;
  localparam int OPC_W = 5;
  localparam int IMM_W = 8;

  // ==========================================================
  // Fixed register numbers
  localparam logic [REGN_W-1:0] TEST_REG_NUM = 5'h18;
  localparam logic [REGN_W-1:0] SP_REG_NUM = 5'h1d;

  // ==========================================================
  // Immediate field positions and scaling
  localparam int IMM4_MSB = 3;
  localparam int IMM5_MSB = 4;
  localparam int IMM8_MSB = 7;
  localparam int SP_ADJ_SHIFT = 3;
  localparam int WORD_SHIFT = 2;
  localparam int PC_MASK_BITS = 2;

  // ==========================================================
  // Reset values of the write-back stage
  localparam logic [XLEN-1:0] WB_DATA_RST = 64'h0;
  localparam logic [REGN_W-1:0] WB_REG_RST = 5'h0;

  // ==========================================================
  // Operation codes on OP_CODE
  localparam logic [OPC_W-1:0] no_op = 5'h00;
  localparam logic [OPC_W-1:0] load_immediate_op = 5'h01;
  localparam logic [OPC_W-1:0] add_immediate_wrap_op_3op = 5'h02;
  localparam logic [OPC_W-1:0] add_immediate_wrap_op_2op = 5'h03;
  localparam logic [OPC_W-1:0] add_immediate_wrap_op_sp = 5'h04;
  localparam logic [OPC_W-1:0] add_immediate_wrap_op_pc = 5'h05;
  localparam logic [OPC_W-1:0] add_immediate_wrap_op_sprel = 5'h06;
  localparam logic [OPC_W-1:0] set_less_imm_signed_op = 5'h07;
  localparam logic [OPC_W-1:0] set_less_imm_unsigned_op = 5'h08;
  localparam logic [OPC_W-1:0] xor_compare_immediate_op = 5'h09;
  localparam logic [OPC_W-1:0] add_wrap_op = 5'h0a;
  localparam logic [OPC_W-1:0] subtract_wrap_op = 5'h0b;
  localparam logic [OPC_W-1:0] dword_add_immediate_wrap_op_3op = 5'h0c;
  localparam logic [OPC_W-1:0] dword_add_immediate_wrap_op_2op = 5'h0d;
  localparam logic [OPC_W-1:0] dword_add_immediate_wrap_op_sp = 5'h0e;
  localparam logic [OPC_W-1:0] dword_add_immediate_wrap_op_pc = 5'h0f;
  localparam logic [OPC_W-1:0] dword_add_immediate_wrap_op_sprel = 5'h10;
  localparam logic [OPC_W-1:0] dword_add_wrap_op = 5'h11;
  localparam logic [OPC_W-1:0] dword_subtract_wrap_op = 5'h12;
  localparam logic [OPC_W-1:0] set_less_signed_op = 5'h13;
  localparam logic [OPC_W-1:0] set_less_unsigned_op = 5'h14;

  // ==========================================================
  // How a result is formed before write-back
  typedef enum logic [2:0] {
    FORM_WORD,
    FORM_DWORD,
    FORM_LT_SIGNED,
    FORM_LT_UNSIGNED,
    FORM_RAW
  } form_t;

endpackage

// [rtl/addsub_unit.sv]
// Shared adder/subtractor with overflow-proof signed and unsigned less-than
`timescale 1ns/1ps
`default_nettype none

module addsub_unit
  import alu_imm_pkg::*;
#(
  parameter int WIDTH = XLEN
) (
  input wire logic [WIDTH-1:0] opa,
  input wire logic [WIDTH-1:0] opb,
  input wire logic sub,
  output logic [WIDTH-1:0] result,
  output logic lt_signed,
  output logic lt_unsigned
);

  logic [WIDTH:0] diff_u;
  logic [WIDTH:0] diff_s;

  // ==========================================================
  // Wrapping sum or difference, no overflow detection at all
  always_comb begin
    if (sub) begin
      result = opa - opb;
    end else begin
      result = opa + opb;
    end
  end

  // ==========================================================
  // Comparisons on one extra bit so an overflowing subtraction never flips the answer
  always_comb begin
    diff_u = {1'b0, opa} - {1'b0, opb};
    diff_s = {opa[WIDTH-1], opa} - {opb[WIDTH-1], opb};
    lt_unsigned = diff_u[WIDTH];
    lt_signed = diff_s[WIDTH];
  end

endmodule

`default_nettype wire

// [test/alu_imm_addsub_monitor.sv]
// Concurrent checks on the compact add/subtract execution stage
`timescale 1ns/1ps
`default_nettype none

module alu_imm_addsub_monitor
  import alu_imm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic OP_VALID,
  input wire logic [OPC_W-1:0] OP_CODE,
  input wire logic MODE_64,
  input wire logic KERNEL_MODE,
  input wire logic [XLEN-1:0] RX_VAL,
  input wire logic [XLEN-1:0] RY_VAL,
  input wire logic [IMM_W-1:0] IMM,
  input wire logic [REGN_W-1:0] RX_NUM,
  input wire logic WB_VALID,
  input wire logic [REGN_W-1:0] WB_REG,
  input wire logic [XLEN-1:0] WB_DATA,
  input wire logic RSV_TRAP,
  input wire logic OVF_TRAP
);
  // ==========================================================
  // Decode helpers: doubleword, trapping, accepted and word ops
  logic dw;
  logic trap;
  logic ok;
  logic wd;
  assign dw = OP_CODE inside {[5'h0c:5'h12]};
  assign trap = OP_VALID && dw && !MODE_64 && !KERNEL_MODE;
  assign ok = OP_VALID && (OP_CODE inside {[5'h01:5'h14]}) && !trap;
  assign wd = OP_CODE inside {5'h02, 5'h03, 5'h04, 5'h06, 5'h0a, 5'h0b};

  default clocking dc @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  // ==========================================================
  // Assertions
  a_no_overflow: assert property (OVF_TRAP == 1'b0)
    else $error("overflow trap raised");
  a_wb_latency: assert property (ok |=> WB_VALID && !RSV_TRAP)
    else $error("accepted op gave no write-back");
  a_dword_trap: assert property (trap |=> RSV_TRAP && !WB_VALID && $stable(WB_DATA))
    else $error("doubleword op did not trap");
  a_idle_quiet: assert property (!ok |=> !WB_VALID)
    else $error("write-back without accepted op");
  a_load_imm: assert property (OP_VALID && OP_CODE == load_immediate_op |=>
    WB_DATA == {56'h0, $past(IMM)} && WB_REG == $past(RX_NUM))
    else $error("load immediate result wrong");
  a_dword_add: assert property (ok && OP_CODE == dword_add_wrap_op |=>
    WB_DATA == $past(RX_VAL) + $past(RY_VAL))
    else $error("doubleword sum wrong");
  a_word_sext: assert property (ok && wd && MODE_64 |=> WB_DATA[63:32] == {32{WB_DATA[31]}})
    else $error("word result not sign-extended");
  a_flag_dest: assert property (OP_VALID && OP_CODE inside {5'h07, 5'h08, 5'h13, 5'h14} |=>
    WB_REG == TEST_REG_NUM && WB_DATA[63:1] == 63'h0)
    else $error("flag result not 0 or 1 in test register");
  a_slt_signed: assert property (OP_VALID && OP_CODE == set_less_signed_op |=>
    WB_DATA[0] == ($signed($past(RX_VAL)) < $signed($past(RY_VAL))))
    else $error("signed less-than wrong");

  // ==========================================================
  // Coverage of the main cases
  c_trap: cover property (RSV_TRAP);
  c_slt: cover property (OP_VALID && OP_CODE == set_less_signed_op);
  c_sext: cover property (ok && wd && MODE_64);
endmodule

bind alu_imm_addsub alu_imm_addsub_monitor mon (.MCLK, .RESET_N, .OP_VALID, .OP_CODE, .MODE_64,
  .KERNEL_MODE, .RX_VAL, .RY_VAL, .IMM, .RX_NUM, .WB_VALID, .WB_REG, .WB_DATA, .RSV_TRAP,
  .OVF_TRAP);

`default_nettype wire

// [test/reg_file_model.sv]
// Register file model that feeds operands and takes write-backs
`timescale 1ns/1ps
`default_nettype none

module reg_file_model
  import alu_imm_pkg::*;
(
  input wire logic clk,
  input wire logic wb_valid,
  input wire logic [REGN_W-1:0] wb_reg,
  input wire logic [XLEN-1:0] wb_data,
  input wire logic [REGN_W-1:0] rx_num,
  input wire logic [REGN_W-1:0] ry_num,
  output logic [XLEN-1:0] rx_val,
  output logic [XLEN-1:0] ry_val,
  output logic [XLEN-1:0] sp_val
);
  logic [XLEN-1:0] regs [32];

  // ==========================================================
  // Registers start cleared so operands are never unknown
  initial begin
    foreach (regs[i]) regs[i] = '0;
  end

  // Write-back port, test register and stack pointer included
  always @(posedge clk) begin
    if (wb_valid) regs[wb_reg] <= wb_data;
  end

  // Read ports
  assign rx_val = regs[rx_num];
  assign ry_val = regs[ry_num];
  assign sp_val = regs[SP_REG_NUM];

  // Lets the bench place operand values
  task automatic preset(input logic [REGN_W-1:0] n, input logic [XLEN-1:0] v);
    regs[n] = v;
  endtask
endmodule

`default_nettype wire

// [test/alu_imm_addsub_test.sv]
// Self-checking bench for the compact add/subtract execution stage
`timescale 1ns/1ps
`default_nettype none

module alu_imm_addsub_test
  import alu_imm_pkg::*;
;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic OP_VALID = 1'b0;
  logic MODE_64 = 1'b0;
  logic KERNEL_MODE = 1'b0;
  logic [OPC_W-1:0] OP_CODE = '0;
  logic [XLEN-1:0] RX_VAL, RY_VAL, SP_VAL;
  logic [XLEN-1:0] BASE_PC = '0;
  logic [IMM_W-1:0] IMM = '0;
  logic [REGN_W-1:0] RX_NUM = 5'h1, RY_NUM = 5'h2, RZ_NUM = 5'h3;
  logic WB_VALID, RSV_TRAP, OVF_TRAP;
  logic [REGN_W-1:0] WB_REG;
  logic [XLEN-1:0] WB_DATA;
  logic [70:0] q[$];
  logic [70:0] exp_v, got_v;
  logic [68:0] last = '0;
  int bad_count = 0;
  int compares = 0;

  always #20 MCLK = ~MCLK;

  alu_imm_addsub dut (.MCLK, .RESET_N, .OP_VALID, .OP_CODE, .MODE_64, .KERNEL_MODE, .RX_VAL,
    .RY_VAL, .SP_VAL, .BASE_PC, .IMM, .RX_NUM, .RY_NUM, .RZ_NUM, .WB_VALID, .WB_REG, .WB_DATA,
    .RSV_TRAP, .OVF_TRAP);

  reg_file_model rf (.clk(MCLK), .wb_valid(WB_VALID), .wb_reg(WB_REG), .wb_data(WB_DATA),
    .rx_num(RX_NUM), .ry_num(RY_NUM), .rx_val(RX_VAL), .ry_val(RY_VAL), .sp_val(SP_VAL));

  // ==========================================================
  // Reference result: destination and 64-bit value
  function automatic logic [68:0] model(input logic [OPC_W-1:0] op, input logic m64,
      input logic [XLEN-1:0] a, b, s, pc, input logic [IMM_W-1:0] im);
    logic [XLEN-1:0] r;
    logic [REGN_W-1:0] d;
    case (op)
      5'h01, 5'h03, 5'h05, 5'h06: d = RX_NUM;
      5'h04, 5'h0e: d = SP_REG_NUM;
      5'h07, 5'h08, 5'h09, 5'h13, 5'h14: d = TEST_REG_NUM;
      5'h0a, 5'h0b, 5'h11, 5'h12: d = RZ_NUM;
      default: d = RY_NUM;
    endcase
    case (op)
      5'h01: r = {56'h0, im};
      5'h02: r = a + 64'($signed(im[3:0]));
      5'h03: r = a + 64'($signed(im));
      5'h04: r = s + 64'($signed({im, 3'h0}));
      5'h05: r = {pc[63:2], 2'h0} + {im, 2'h0};
      5'h06: r = s + {im, 2'h0};
      5'h07: r = 64'($signed(a) < $signed({56'h0, im}));
      5'h08: r = 64'(a < {56'h0, im});
      5'h09: r = a ^ {56'h0, im};
      5'h0a: r = a + b;
      5'h0b: r = a - b;
      5'h0c: r = a + 64'($signed(im[3:0]));
      5'h0d: r = b + 64'($signed(im[4:0]));
      5'h0e: r = s + 64'($signed({im, 3'h0}));
      5'h0f: r = {pc[63:2], 2'h0} + {im[4:0], 2'h0};
      5'h10: r = s + {im[4:0], 2'h0};
      5'h11: r = a + b;
      5'h12: r = a - b;
      5'h13: r = 64'($signed(a) < $signed(b));
      default: r = 64'(a < b);
    endcase
    if (op inside {5'h02, 5'h03, 5'h04, 5'h06, 5'h0a, 5'h0b}) begin
      r = m64 ? 64'($signed(r[31:0])) : {32'h0, r[31:0]};
    end
    return {d, r};
  endfunction

  // ==========================================================
  // Driver: one operation at a falling edge, expectation queued for codes 0x01-0x14 only
  task automatic issue(input logic [OPC_W-1:0] op, input logic m64, kern,
      input logic [XLEN-1:0] a, b);
    logic [XLEN-1:0] s;
    @(negedge MCLK);
    s = {$urandom, $urandom};
    if (m64 && op inside {5'h02, 5'h03, 5'h04, 5'h06, 5'h0a, 5'h0b}) begin
      a = 64'($signed(a[31:0]));
      b = 64'($signed(b[31:0]));
      s = 64'($signed(s[31:0]));
    end
    OP_VALID = 1'b1;
    OP_CODE = op;
    MODE_64 = m64;
    KERNEL_MODE = kern;
    IMM = 8'($urandom);
    BASE_PC = {$urandom, $urandom};
    RX_NUM = 5'($urandom % 8 + 1);
    RY_NUM = RX_NUM + 5'h8;
    RZ_NUM = 5'($urandom % 4 + 17);
    rf.preset(RX_NUM, a);
    rf.preset(RY_NUM, b);
    rf.preset(SP_REG_NUM, s);
    if (op >= 5'h01 && op <= 5'h14) begin
      if (op >= 5'h0c && op <= 5'h12 && !m64 && !kern) begin
        q.push_back({2'b10, last});
      end else begin
        last = model(op, m64, a, b, s, BASE_PC, IMM);
        q.push_back({2'b01, last});
      end
    end
  endtask

  // Idle cycle with a junk code that must be ignored
  task automatic idle();
    @(negedge MCLK);
    OP_VALID = 1'b0;
    OP_CODE = 5'($urandom);
  endtask

  // ==========================================================
  // Monitor: each pulse is matched with the oldest expectation
  always @(negedge MCLK) begin
    if (RESET_N && (WB_VALID || RSV_TRAP)) begin
      exp_v = (q.size() > 0) ? q.pop_front() : '1;
      got_v = {RSV_TRAP, WB_VALID, WB_REG, WB_DATA};
      compares++;
      if (got_v !== exp_v) begin
        bad_count++;
        $display("mismatch at %0t: expected %h got %h", $time, exp_v, got_v);
      end
      // Overflow exception must stay quiet whatever the operands
      compares++;
      if (OVF_TRAP !== 1'b0) begin
        bad_count++;
        $display("mismatch at %0t: expected %h got %h", $time, 1'b0, OVF_TRAP);
      end
    end
  end

  task automatic finish_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence: codes 0x00-0x14 and 0x1f in all four mode settings, boundary operands first
  initial begin
    void'($urandom(20));
    repeat (2) @(negedge MCLK);
    RESET_N = 1'b1;
    for (int i = 0; i < 4; i++) begin
      for (int op = 0; op < 22; op++) begin
        for (int m = 0; m < 4; m++) begin
          issue(5'(op == 21 ? 31 : op), m[1], m[0],
            i == 0 ? 64'h8000000000000000 : i == 1 ? 64'h7fffffff : {$urandom, $urandom},
            i == 0 ? 64'h7fffffffffffffff : i == 1 ? 64'h1 : {$urandom, $urandom});
          if ($urandom % 4 == 0) idle();
        end
      end
      if (i == 2) begin
        idle();
        idle();
        @(negedge MCLK);
        RESET_N = 1'b0;
        repeat (2) @(negedge MCLK);
        compares++;
        if (WB_VALID !== 1'b0 || WB_DATA !== WB_DATA_RST) begin
          bad_count++;
          $display("mismatch at %0t: expected %h got %h", $time, WB_DATA_RST, WB_DATA);
        end
        last = '0;
        RESET_N = 1'b1;
      end
    end
    for (int k = 0; k < 10 && q.size() > 0; k++) @(negedge MCLK);
    if (q.size() > 0) bad_count++;
    finish_test();
  end
endmodule

`default_nettype wire
